// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_pkt_start = 1'b0, rx_dw_read = 1'b0;
    logic rx_pkt_last_dw = 1'b0, tx_sts_full = 1'b0, frame_pend = 1'b0;
    wire [31:0] reg_rdata;
    wire irq, tx_run, tx_frame_busy, tx_status_flush, tx_data_flush, rx_fill_active;
    wire [4:0] rx_leading_byte_offset;
    wire [3:0] rx_fill_dw;
    int fails = 0;
    int checks_done = 0;
    tfc_fifo_cfg i_tfc_fifo_cfg (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .rx_pkt_start, .rx_dw_read, .rx_pkt_last_dw,
        .rx_leading_byte_offset, .rx_fill_dw, .rx_fill_active, .tx_frame_busy,
        .tx_sts_full, .tx_run, .tx_status_flush, .tx_data_flush);
    tfc_tx_partner i_tfc_tx_partner (.clk_sys, .rst_n, .tx_run, .frame_pend, .tx_frame_busy);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // sampled at the edge, so reg_rdata still holds the slot after the read
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        chk("rdata", reg_rdata, exp);
    endtask
    task automatic pkt(input int n);
        rx_pkt_start <= 1'b1;
        @(posedge clk_sys);
        rx_pkt_start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_dw_read <= 1'b1;
            rx_pkt_last_dw <= (i == n - 1);
            @(posedge clk_sys);
        end
        rx_dw_read <= 1'b0;
        rx_pkt_last_dw <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(1);
        rd(8'h6c, 32'h0);
        rd(8'h70, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h6c, 32'hffff_ffff);
        rd(8'h6c, 32'hc000_1f00);
        wr(8'h6c, 32'h0000_1300);
        pkt(2);
        chk("offset", rx_leading_byte_offset, 32'h13);
        wr(8'h6c, 32'h0000_0f00);
        tick(2);
        chk("offset", rx_leading_byte_offset, 32'h13);
        rx_dw_read <= 1'b1;
        tick(1);
        rx_dw_read <= 1'b0;
        tick(2);
        chk("offset", rx_leading_byte_offset, 32'h0f);
        for (int c = 0; c < 4; c++) begin
            wr(8'h6c, {c[1:0], 30'h0});
            pkt(5);
            tick(1);
            chk("fill", rx_fill_dw, (c == 1 || c == 2) ? 32'h3 : 32'h0);
            chk("fill_on", rx_fill_active, (c == 1 || c == 2) ? 32'h1 : 32'h0);
        end
        frame_pend <= 1'b1;
        wr(8'h70, 32'h2);
        tick(3);
        chk("run", tx_run, 32'h1);
        tick(2);
        wr(8'h70, 32'h3);
        tick(3);
        chk("run", tx_run, 32'h0);
        chk("busy", tx_frame_busy, 32'h1);
        frame_pend <= 1'b0;
        wr(8'h70, 32'h2);
        rd(8'h70, 32'h3);
        repeat (100) if (tx_frame_busy !== 1'b0) @(posedge clk_sys);
        chk("busy", tx_frame_busy, 32'h0);
        if (fails != 0)
            end_sim();
        tick(3);
        rd(8'h70, 32'h0);
        rd(8'h78, 32'h2);
        chk("irq", irq, 32'h0);
        wr(8'h7c, 32'h3);
        tick(3);
        chk("irq", irq, 32'h1);
        wr(8'h78, 32'h2);
        tick(3);
        chk("irq", irq, 32'h0);
        wr(8'h70, 32'h0000_c000);
        tick(1);
        chk("sflush", tx_status_flush, 32'h1);
        chk("dflush", tx_data_flush, 32'h1);
        rd(8'h70, 32'h0);
        wr(8'h70, 32'h2);
        tick(3);
        tx_sts_full <= 1'b1;
        tick(4);
        chk("run", tx_run, 32'h0);
        chk("irq", irq, 32'h1);
        wr(8'h70, 32'h6);
        tick(3);
        chk("run", tx_run, 32'h1);
        rd(8'h78, 32'h1);
        tx_sts_full <= 1'b0;
        wr(8'h78, 32'h1);
        tx_sts_full <= 1'b1;
        tick(3);
        rd(8'h78, 32'h1);
        end_sim();
    end
endmodule

// ===== tfc_consts.vh
`ifndef TFC_CONSTS_VH
`define TFC_CONSTS_VH

`define TFC_ADDR_W 8
`define TFC_OFF_RXCFG 8'h6c
`define TFC_OFF_TXCFG 8'h70
`define TFC_OFF_INT_STS 8'h78
`define TFC_OFF_INT_EN 8'h7c

`define TFC_RX_ALIGN_HI 31
`define TFC_RX_ALIGN_LO 30
`define TFC_RX_OFF_HI 12
`define TFC_RX_OFF_LO 8
`define TFC_RX_DW_OFF_LO 10
`define TFC_TX_SFLUSH_BIT 15
`define TFC_TX_DFLUSH_BIT 14
`define TFC_TX_SAO_BIT 2
`define TFC_TX_ON_BIT 1
`define TFC_TX_STOP_BIT 0

`define TFC_RX_ALIGN_RST 2'b00
`define TFC_RX_OFF_RST 5'h00

`define TFC_ALIGN_4 2'b00
`define TFC_ALIGN_16 2'b01
`define TFC_ALIGN_32 2'b10

`define TFC_INT_TSFF 0
`define TFC_INT_STOPPED 1
`define TFC_INT_W 2

`endif

// ===== tfc_fifo_cfg.v
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "tfc_consts.vh"

// Functional notes
// (RULE1) received data is shifted by a programmable 0-31 byte offset, reset zero
// (RULE2) host changes low two offset bits only with receiver halted and purged
// (RULE3) upper three offset bits may change live, effective next doubleword read
// (RULE4) end alignment code: 00 4-byte, 01 16-byte, 10 32-byte, 11 reserved
// (RULE5) filler doublewords pad buffer end to alignment; host discards them
// (RULE6) host sets end alignment before a packet, changes only between packets
// (RULE7) writing one to status flush zeroes status FIFO pointers, self-clears
// (RULE8) writing one to data flush zeroes data FIFO pointers, self-clears
// (RULE9) with overrun allow clear, transmission suspends while status FIFO full
// (RULE10) status-full interrupt independent of the overrun allow setting
// (RULE11) transmitter enable one sends held data; resets to zero
// (RULE12) enable clears itself once stop requested and transmitter halted
// (RULE13) stop request finishes current frame then ceases transmitting
// (RULE14) stop bit self-clears on halt; writes ignored while it reads one
// (RULE15) reserved bits read zero and ignore writes
module tfc_fifo_cfg (
    input wire clk_sys,
    input wire rst_n,
    input wire [`TFC_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg irq,
    input wire rx_pkt_start,
    input wire rx_dw_read,
    input wire rx_pkt_last_dw,
    output reg [4:0] rx_leading_byte_offset,
    output reg [3:0] rx_fill_dw,
    output reg rx_fill_active,
    input wire tx_frame_busy,
    input wire tx_sts_full,
    output reg tx_run,
    output reg tx_status_flush,
    output reg tx_data_flush
);
    reg [4:0] rx_off_q;
    reg [1:0] rx_align_q;
    reg sao_q;
    reg [`TFC_INT_W-1:0] int_sts_q;
    reg [`TFC_INT_W-1:0] int_en_q;
    reg sts_full_q;

    wire wr_tx = reg_wr && (reg_addr == `TFC_OFF_TXCFG);
    wire wr_rx = reg_wr && (reg_addr == `TFC_OFF_RXCFG);
    wire tx_on_w;
    wire stop_w;
    wire run_w;
    wire stopped_w;
    wire [4:0] off_w;
    wire [3:0] fill_w;
    wire fill_act_w;

    tfc_rx_align u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .offset_cfg(rx_off_q),
        .align_cfg(rx_align_q),
        .pkt_start(rx_pkt_start),
        .dw_read(rx_dw_read),
        .pkt_last_dw(rx_pkt_last_dw),
        .cur_offset_q(off_w),
        .fill_dw_q(fill_w),
        .fill_active_q(fill_act_w)
    );

    tfc_tx_ctrl u_tx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tx_on_set(wr_tx && reg_wdata[`TFC_TX_ON_BIT]),
        .tx_on_clr(wr_tx && !reg_wdata[`TFC_TX_ON_BIT]),
        .stop_req(wr_tx && reg_wdata[`TFC_TX_STOP_BIT]),
        .frame_busy(tx_frame_busy),
        .sts_full(tx_sts_full),
        .overrun_allow(sao_q),
        .tx_on_q(tx_on_w),
        .stop_q(stop_w),
        .tx_run_q(run_w),
        .stopped_pulse_q(stopped_w)
    );

    wire [`TFC_INT_W-1:0] ev;
    assign ev = {stopped_w, tx_sts_full && !sts_full_q}; // RULE10

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_off_q <= `TFC_RX_OFF_RST;
            rx_align_q <= `TFC_RX_ALIGN_RST;
            sao_q <= 1'b0;
            int_sts_q <= {`TFC_INT_W{1'b0}};
            int_en_q <= {`TFC_INT_W{1'b0}};
            sts_full_q <= 1'b0;
            tx_status_flush <= 1'b0;
            tx_data_flush <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            irq <= 1'b0;
            tx_run <= 1'b0;
            rx_leading_byte_offset <= 5'h00;
            rx_fill_dw <= 4'h0;
            rx_fill_active <= 1'b0;
        end else begin
            sts_full_q <= tx_sts_full;
            if (wr_rx) begin
                rx_off_q <= reg_wdata[`TFC_RX_OFF_HI:`TFC_RX_OFF_LO]; // RULE1
                rx_align_q <= reg_wdata[`TFC_RX_ALIGN_HI:`TFC_RX_ALIGN_LO];
            end
            if (wr_tx)
                sao_q <= reg_wdata[`TFC_TX_SAO_BIT];
            // flush strobes are one-cycle pulses; the bits read back as zero
            tx_status_flush <= wr_tx && reg_wdata[`TFC_TX_SFLUSH_BIT]; // RULE7
            tx_data_flush <= wr_tx && reg_wdata[`TFC_TX_DFLUSH_BIT]; // RULE8
            if (reg_wr && reg_addr == `TFC_OFF_INT_EN)
                int_en_q <= reg_wdata[`TFC_INT_W-1:0];
            // set wins over write-one-to-clear
            if (reg_wr && reg_addr == `TFC_OFF_INT_STS)
                int_sts_q <= (int_sts_q & ~reg_wdata[`TFC_INT_W-1:0]) | ev;
            else
                int_sts_q <= int_sts_q | ev;
            irq <= |(int_sts_q & int_en_q);
            tx_run <= run_w;
            rx_leading_byte_offset <= off_w;
            rx_fill_dw <= fill_w;
            rx_fill_active <= fill_act_w;
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `TFC_OFF_RXCFG: begin
                        reg_rdata[`TFC_RX_ALIGN_HI:`TFC_RX_ALIGN_LO] <= rx_align_q;
                        reg_rdata[`TFC_RX_OFF_HI:`TFC_RX_OFF_LO] <= rx_off_q; // RULE15
                    end
                    `TFC_OFF_TXCFG: begin
                        reg_rdata[`TFC_TX_SAO_BIT] <= sao_q;
                        reg_rdata[`TFC_TX_ON_BIT] <= tx_on_w;
                        reg_rdata[`TFC_TX_STOP_BIT] <= stop_w;
                    end
                    `TFC_OFF_INT_STS: reg_rdata[`TFC_INT_W-1:0] <= int_sts_q;
                    `TFC_OFF_INT_EN: reg_rdata[`TFC_INT_W-1:0] <= int_en_q;
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ===== tfc_fifo_cfg_props.sv
`timescale 1ns/1ns
module tfc_fifo_cfg_props (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire rx_dw_read,
    input wire [4:0] rx_leading_byte_offset,
    input wire tx_frame_busy,
    input wire tx_sts_full,
    input wire tx_run,
    input wire tx_status_flush,
    input wire tx_data_flush
);
    logic sao_q;
    logic [2:0] dw_off_q;
    wire tx_wr = reg_wr && reg_addr == 8'h70;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sao_q <= 1'b0;
            dw_off_q <= 3'h0;
        end else begin
            if (tx_wr)
                sao_q <= reg_wdata[2];
            if (reg_wr && reg_addr == 8'h6c)
                dw_off_q <= reg_wdata[12:10];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_tx_reserved: assert property ($past(reg_rd && reg_addr == 8'h70) |->
        reg_rdata[31:16] == 16'h0 && reg_rdata[15:3] == 13'h0) else $error("reserved set");
    a_sflush_pulse: assert property (tx_wr && reg_wdata[15] ##1
        !(tx_wr && reg_wdata[15]) |-> tx_status_flush ##1 !tx_status_flush)
        else $error("status flush pulse");
    a_dflush_cause: assert property (tx_data_flush |->
        $past(tx_wr && reg_wdata[14])) else $error("data flush uncaused");
    a_run_start: assert property (tx_wr && reg_wdata[1:0] == 2'b10 &&
        !tx_frame_busy ##1 !tx_sts_full |-> ##2 tx_run) else $error("run late");
    a_full_stall: assert property ((tx_sts_full && !sao_q) [*3] |-> !tx_run)
        else $error("run while full");
    a_stop_halts: assert property (tx_wr && reg_wdata[0] && tx_run |-> ##3 !tx_run)
        else $error("stop ignored");
    a_dw_offset: assert property (rx_dw_read |-> ##2
        rx_leading_byte_offset[4:2] == $past(dw_off_q, 2)) else $error("offset stale");
    c_flush: cover property (tx_status_flush && tx_data_flush);
    c_drain: cover property (tx_frame_busy && !tx_run);
    c_stall: cover property (tx_sts_full && !tx_run);
endmodule
bind tfc_fifo_cfg tfc_fifo_cfg_props i_tfc_fifo_cfg_props (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_dw_read, .rx_leading_byte_offset,
    .tx_frame_busy, .tx_sts_full, .tx_run, .tx_status_flush, .tx_data_flush);

// ===== tfc_rx_align.v
`timescale 1ns/1ns
`include "tfc_consts.vh"

// receive read path: leading offset and end-alignment fill count
module tfc_rx_align (
    input wire clk_sys,
    input wire rst_n,
    input wire [4:0] offset_cfg,
    input wire [1:0] align_cfg,
    input wire pkt_start,
    input wire dw_read,
    input wire pkt_last_dw,
    output reg [4:0] cur_offset_q,
    output reg [3:0] fill_dw_q,
    output reg fill_active_q
);
    // doublewords per alignment unit, minus one, as a mask
    function [2:0] tfc_align_mask;
        input [1:0] code;
        begin
            case (code)
                `TFC_ALIGN_4: tfc_align_mask = 3'h0;
                `TFC_ALIGN_16: tfc_align_mask = 3'h3;
                `TFC_ALIGN_32: tfc_align_mask = 3'h7;
                default: tfc_align_mask = 3'h0;
            endcase
        end
    endfunction

    reg [2:0] dw_cnt_q;
    reg [2:0] fill_cnt;
    reg [2:0] msk;

    always @* begin
        msk = tfc_align_mask(align_cfg); // RULE4
        fill_cnt = (3'h0 - (dw_cnt_q + 3'h1)) & msk;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_offset_q <= 5'h00;
            dw_cnt_q <= 3'h0;
            fill_dw_q <= 4'h0;
            fill_active_q <= 1'b0;
        end else begin
            if (pkt_start) begin
                cur_offset_q <= offset_cfg; // RULE1
                dw_cnt_q <= 3'h0;
            end else if (dw_read) begin
                // byte bits stay latched; dword bits follow on the next read
                cur_offset_q <= {offset_cfg[4:2], cur_offset_q[1:0]}; // RULE3
                dw_cnt_q <= dw_cnt_q + 3'h1;
            end
            // a new packet drops any filler the host left unread
            if (pkt_start) begin
                fill_dw_q <= 4'h0;
                fill_active_q <= 1'b0;
            end else if (dw_read && pkt_last_dw) begin
                fill_dw_q <= {1'b0, fill_cnt}; // RULE5
                fill_active_q <= (fill_cnt != 3'h0);
            end else if (fill_active_q && dw_read) begin
                fill_dw_q <= fill_dw_q - 4'h1;
                fill_active_q <= (fill_dw_q != 4'h1);
            end
        end
    end
endmodule

// ===== tfc_tx_ctrl.v
`timescale 1ns/1ns

// transmit on/stop handshake; a frame in flight always completes
module tfc_tx_ctrl (
    input wire clk_sys,
    input wire rst_n,
    input wire tx_on_set,
    input wire tx_on_clr,
    input wire stop_req,
    input wire frame_busy,
    input wire sts_full,
    input wire overrun_allow,
    output reg tx_on_q,
    output reg stop_q,
    output reg tx_run_q,
    output reg stopped_pulse_q
);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_on_q <= 1'b0;
            stop_q <= 1'b0;
            tx_run_q <= 1'b0;
            stopped_pulse_q <= 1'b0;
        end else begin
            stopped_pulse_q <= 1'b0;
            if (stop_q && !frame_busy) begin
                tx_on_q <= 1'b0; // RULE12
                stop_q <= 1'b0; // RULE14
                stopped_pulse_q <= 1'b1;
            end else begin
                if (tx_on_set)
                    tx_on_q <= 1'b1;
                else if (tx_on_clr)
                    tx_on_q <= 1'b0;
                if (stop_req && !stop_q)
                    stop_q <= 1'b1; // RULE14
            end
            // a new frame may not start while stopping, or while status is full with overrun allow clear
            tx_run_q <= tx_on_q && !stop_q && !(sts_full && !overrun_allow); // RULE9 RULE11 RULE13
        end
    end
endmodule

// ===== tfc_tx_partner.sv
`timescale 1ns/1ns
// once started a frame runs to its end whatever tx_run does
module tfc_tx_partner #(
    parameter FRAME_LEN = 20
) (
    input wire clk_sys,
    input wire rst_n,
    input wire tx_run,
    input wire frame_pend,
    output logic tx_frame_busy
);
    logic [7:0] left_q;
    assign tx_frame_busy = left_q != 8'h0;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            left_q <= 8'h0;
        else if (left_q != 8'h0)
            left_q <= left_q - 8'h1;
        else if (tx_run && frame_pend)
            left_q <= 8'(FRAME_LEN);
    end
endmodule
